// >>> shared/flash_wp_pkg.sv
`default_nettype none
package flash_wp_pkg;
    // Opcodes
    localparam logic [7:0] LATCH_SET_OP    = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_OP  = 8'h04;
    localparam logic [7:0] WRITE_ARM_OP    = 8'h50;
    localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
    localparam logic [7:0] STATUS_READ_OP  = 8'h05;
    localparam logic [7:0] IDENT_OP_A      = 8'h90;
    localparam logic [7:0] IDENT_OP_B      = 8'hab;
    // Identification codes, values arbitrary
    localparam logic [7:0] MAKER_CODE      = 8'h5a;
    localparam logic [7:0] PART_CODE       = 8'h3c;
    // Status register bit positions
    localparam int         ST_BUSY         = 0;
    localparam int         ST_WRITE_LATCH  = 1;
    localparam int         ST_LEVEL_LO     = 2;
    localparam int         ST_LEVEL_HI     = 3;
    localparam int         ST_AUTO_INC     = 6;
    localparam int         ST_LOCKDOWN     = 7;
    // Status reset value: levels set, lockdown clear
    localparam logic [7:0] STATUS_RESET    = 8'h0c;
    // Frame layout in bits
    localparam int         OP_BITS         = 8;
    localparam int         ADDR_BITS       = 24;
    localparam logic [5:0] ADDR_END        = 6'd32;
    localparam logic [5:0] DATA_END        = 6'd16;
    // Host link clock divider: half period in clk cycles
    localparam logic [3:0] SCK_HALF        = 4'd4;
    // Host minimum chip select high time in clk cycles
    localparam logic [3:0] CS_HIGH_GAP     = 4'd8;
endpackage : flash_wp_pkg
`default_nettype wire

// >>> shared/flash_spi_if.sv
`default_nettype none
interface flash_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_n;
    modport device (input cs_n, input sck, input mosi, input wp_n,
                    output miso, output miso_oe);
    modport host (output cs_n, output sck, output mosi, output wp_n,
                  input miso, input miso_oe);
endinterface : flash_spi_if
`default_nettype wire

// >>> verilog/flash_wp_device.sv
// Overview of operation
// - Latch set command sets write latch
// - Latch set before writes left to host user
// - Latch set acts at chip select rise
// - Latch clear zeroes latch and auto-increment
// - Latch clear acts at chip select rise
// - Arm only enables next status write
// - Host frames arm opcode with chip select
// - Status write changes only level, lockdown
// - Host sends status write right after arm
// - Ignore status write when pin low, locked
// - Pin low: lockdown may only set
// - Pin high: all three bits writable
// - Check lock and pin at chip select rise
// - Status write applied at chip select rise
// - Two identification opcodes plus 24-bit address
// - Address zero maker, one part code
// - Identification bytes alternate until deselect
// - Latch clear opcode ends auto-increment
// - Status readable at any time
`default_nettype none
module flash_wp_device
    import flash_wp_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        reset,
    // Link
    flash_spi_if.device      spi,
    // Device state view
    output logic [7:0]       status_out,
    output logic             armed_out
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_IDENT = 3'b100
    } phase_t;

    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] sck_sync;
        logic [2:0] mosi_sync;
        logic [2:0] wp_sync;
        logic       cs_n;
        logic       sck;
        logic       wp_high;
        phase_t     phase;
        logic [5:0] bit_cnt;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] data;
        logic [7:0] tx;
        logic       id_sel;
        logic       oe;
        logic [7:0] status;
        logic       armed;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // Stable level once second and third stages agree
    function automatic logic settle(input logic [2:0] sync, input logic prev);
        settle = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction : settle

    // Byte for current identification address parity
    function automatic logic [7:0] id_byte(input logic sel);
        id_byte = sel ? PART_CODE : MAKER_CODE;
    endfunction : id_byte

    // Frame decode, sampling and command execution
    always_comb
    begin
        logic cs_now;
        logic sck_now;
        logic wp_high;
        logic rise;
        logic fall;
        logic cs_rise;
        logic [7:0] sr;
        cs_now  = 1'b1;
        sck_now = 1'b0;
        wp_high = 1'b0;
        rise    = 1'b0;
        fall    = 1'b0;
        cs_rise = 1'b0;
        sr      = 8'h00;
        s_next = s_reg;
        s_next.cs_sync   = {s_reg.cs_sync[1:0], spi.cs_n};
        s_next.sck_sync  = {s_reg.sck_sync[1:0], spi.sck};
        s_next.mosi_sync = {s_reg.mosi_sync[1:0], spi.mosi};
        s_next.wp_sync   = {s_reg.wp_sync[1:0], spi.wp_n};
        cs_now  = settle(s_reg.cs_sync, s_reg.cs_n);
        sck_now = settle(s_reg.sck_sync, s_reg.sck);
        wp_high = settle(s_reg.wp_sync, s_reg.wp_high);
        s_next.cs_n = cs_now;
        s_next.wp_high = wp_high;
        s_next.sck  = sck_now;
        rise    = !cs_now && sck_now && !s_reg.sck;
        fall    = !cs_now && !sck_now && s_reg.sck;
        cs_rise = cs_now && !s_reg.cs_n;
        sr      = s_reg.status;

        if (cs_rise)
        begin
            s_next.phase = ST_IDLE;
            s_next.oe    = 1'b0;
            // Commands act only at the end of the frame
            if (s_reg.bit_cnt == 6'(OP_BITS) && s_reg.opcode == LATCH_SET_OP)
            begin
                sr[ST_WRITE_LATCH] = 1'b1;
                s_next.armed = 1'b0;
            end
            else if (s_reg.bit_cnt == 6'(OP_BITS) && s_reg.opcode == LATCH_CLEAR_OP)
            begin
                sr[ST_WRITE_LATCH] = 1'b0;
                sr[ST_AUTO_INC]    = 1'b0;
                s_next.armed = 1'b0;
            end
            else if (s_reg.bit_cnt == 6'(OP_BITS) && s_reg.opcode == WRITE_ARM_OP)
                s_next.armed = 1'b1;
            else if (s_reg.bit_cnt == DATA_END && s_reg.opcode == STATUS_WRITE_OP)
            begin
                s_next.armed = 1'b0;
                // Pin and lock sampled just before the rise
                if (s_reg.armed && (wp_high || !s_reg.status[ST_LOCKDOWN]))
                begin
                    sr[ST_LEVEL_LO] = s_reg.data[ST_LEVEL_LO];
                    sr[ST_LEVEL_HI] = s_reg.data[ST_LEVEL_HI];
                    sr[ST_LOCKDOWN] = s_reg.data[ST_LOCKDOWN];
                end
            end
            else if (s_reg.bit_cnt != 6'd0)
                s_next.armed = 1'b0;
            s_next.status  = sr;
            s_next.bit_cnt = 6'd0;
        end
        else if (cs_now)
        begin
            s_next.phase   = ST_IDLE;
            s_next.bit_cnt = 6'd0;
            s_next.oe      = 1'b0;
        end
        else if (rise)
        begin
            if (s_reg.phase == ST_IDLE)
                s_next.phase = ST_SHIFT;
            if (s_reg.bit_cnt != 6'h3f)
                s_next.bit_cnt = s_reg.bit_cnt + 6'd1;
            if (s_reg.bit_cnt < 6'(OP_BITS) && s_reg.phase != ST_IDENT)
                s_next.opcode = {s_reg.opcode[6:0], s_reg.mosi_sync[2]};
            else
            begin
                s_next.addr = {s_reg.addr[22:0], s_reg.mosi_sync[2]};
                s_next.data = {s_reg.data[6:0], s_reg.mosi_sync[2]};
            end
        end
        else if (fall)
        begin
            // Output shifting on falling edges, modes 0 and 3
            if (s_reg.bit_cnt == 6'(OP_BITS) && s_reg.opcode == STATUS_READ_OP)
            begin
                s_next.tx = s_reg.status;
                s_next.oe = 1'b1;
            end
            else if (s_reg.bit_cnt == ADDR_END && s_reg.phase == ST_SHIFT
                     && (s_reg.opcode == IDENT_OP_A || s_reg.opcode == IDENT_OP_B))
            begin
                s_next.phase  = ST_IDENT;
                s_next.id_sel = !s_reg.addr[0];
                s_next.tx     = id_byte(s_reg.addr[0]);
                s_next.oe     = 1'b1;
                s_next.bit_cnt = 6'd1;
            end
            else if (s_reg.phase == ST_IDENT && s_reg.bit_cnt == 6'd9)
            begin
                s_next.tx      = id_byte(s_reg.id_sel);
                s_next.id_sel  = !s_reg.id_sel;
                s_next.bit_cnt = 6'd1;
            end
            else if (s_reg.oe && s_reg.bit_cnt > 6'(OP_BITS) && s_reg.opcode == STATUS_READ_OP
                     && s_reg.bit_cnt[2:0] == 3'd0)
                s_next.tx = s_reg.status;
            else if (s_reg.oe)
                s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_reg <= '{cs_sync: 3'b111, sck_sync: 3'b000, mosi_sync: 3'b000,
                       wp_sync: 3'b111, cs_n: 1'b1, sck: 1'b0, wp_high: 1'b1, phase: ST_IDLE,
                       bit_cnt: 6'd0, opcode: 8'h00, addr: 24'h000000, data: 8'h00,
                       tx: 8'h00, id_sel: 1'b0, oe: 1'b0, status: STATUS_RESET,
                       armed: 1'b0};
        end
        else
            s_reg <= s_next;
    end

    // Outputs
    assign spi.miso     = s_reg.tx[7];
    assign spi.miso_oe  = s_reg.oe;
    assign status_out   = s_reg.status;
    assign armed_out    = s_reg.armed;
endmodule : flash_wp_device
`default_nettype wire

// >>> verilog/flash_wp_host.sv
`default_nettype none
module flash_wp_host
    import flash_wp_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        reset,
    // Link
    flash_spi_if.host        spi,
    // User request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_op,
    input  wire logic [5:0]  req_bits,
    input  wire logic [31:0] req_tx,
    input  wire logic [5:0]  req_rx_bits,
    input  wire logic        wp_level,
    // User answer
    output logic             done,
    output logic [15:0]      rx_data
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_XFER = 3'b010,
        H_GAP  = 3'b100
    } hstate_t;

    typedef struct packed {
        hstate_t     st;
        logic        cs_n;
        logic        sck;
        logic [3:0]  div;
        logic [6:0]  left;
        logic [39:0] sh;
        logic [15:0] rx;
        logic        done;
        logic [2:0]  miso_sync;
    } host_t;

    host_t h_reg;
    host_t h_next;

    // Framing, clock divider and shifting
    always_comb
    begin
        h_next = h_reg;
        h_next.done = 1'b0;
        h_next.miso_sync = {h_reg.miso_sync[1:0], spi.miso};
        case (h_reg.st)
            H_IDLE:
                if (req_valid)
                begin
                    // Opcode then payload, MSB first, chip select low throughout
                    h_next.sh   = {req_op, req_tx};
                    h_next.left = 7'(OP_BITS) + {1'b0, req_bits} + {1'b0, req_rx_bits};
                    h_next.cs_n = 1'b0;
                    h_next.div  = 4'd0;
                    h_next.st   = H_XFER;
                end
            H_XFER:
                if (h_reg.div == SCK_HALF - 4'd1)
                begin
                    h_next.div = 4'd0;
                    if (!h_reg.sck)
                        h_next.sck = 1'b1;
                    else
                    begin
                        // Sample at the end of the high phase: the answer lags each
                        // fall by the synchronisers of both ends
                        h_next.sck  = 1'b0;
                        h_next.rx   = {h_reg.rx[14:0], h_reg.miso_sync[2]};
                        h_next.sh   = {h_reg.sh[38:0], 1'b0};
                        h_next.left = h_reg.left - 7'd1;
                        if (h_reg.left == 7'd1)
                        begin
                            // Raise select so the command executes
                            h_next.cs_n = 1'b1;
                            h_next.done = 1'b1;
                            h_next.st   = H_GAP;
                        end
                    end
                end
                else
                    h_next.div = h_reg.div + 4'd1;
            H_GAP:
                if (h_reg.div == CS_HIGH_GAP)
                begin
                    h_next.div = 4'd0;
                    h_next.st  = H_IDLE;
                end
                else
                    h_next.div = h_reg.div + 4'd1;
            default:
                h_next.st = H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            h_reg <= '{st: H_IDLE, cs_n: 1'b1, sck: 1'b0, div: 4'd0, left: 7'd0,
                       sh: 40'h0, rx: 16'h0, done: 1'b0, miso_sync: 3'b000};
        else
            h_reg <= h_next;
    end

    // Outputs; latch set before writes is the user's sequencing
    assign req_ready = (h_reg.st == H_IDLE);
    assign spi.cs_n  = h_reg.cs_n;
    assign spi.sck   = h_reg.sck;
    assign spi.mosi  = h_reg.sh[39];
    assign spi.wp_n  = wp_level;
    assign done      = h_reg.done;
    assign rx_data   = h_reg.rx;
endmodule : flash_wp_host
`default_nettype wire

// >>> tb/flash_wp_monitor.sv
`default_nettype none
module flash_wp_monitor
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic wp_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Link clock shape and framing
    property p_idle_sck;
        cs_n |-> !sck;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("sck not low while deselected");
    property p_sck_high;
        $rose(sck) |-> sck[*4] ##1 !sck;
    endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high phase length wrong");
    property p_sck_low;
        $fell(sck) |-> (!sck)[*4];
    endproperty
    a_sck_low: assert property (p_sck_low) else $error("sck low phase too short");
    property p_lead_in;
        $fell(cs_n) |-> (!sck)[*4];
    endproperty
    a_lead_in: assert property (p_lead_in) else $error("sck rose too soon after select");
    property p_mosi_stable;
        $rose(sck) |=> $stable(mosi)[*3];
    endproperty
    a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved while sck high");
    property p_cs_gap;
        $rose(cs_n) |-> cs_n[*8];
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("chip select high gap too short");
    // Device output enable only inside an answer
    property p_oe_release;
        $rose(cs_n) |-> ##[0:6] !miso_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("miso kept after deselect");
    property p_oe_idle;
        cs_n[*8] |-> !miso_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
    property p_oe_opcode;
        $fell(cs_n) |-> (!miso_oe)[*8];
    endproperty
    a_oe_opcode: assert property (p_oe_opcode) else $error("miso driven during opcode");
    // Answer bit moves only while driven, and holds through each high phase
    property p_miso_quiet;
        $changed(miso) |-> miso_oe;
    endproperty
    a_miso_quiet: assert property (p_miso_quiet) else $error("miso moved while released");
    property p_miso_hold;
        $rose(sck) |=> $stable(miso)[*3];
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sck high");

    // Main scenarios
    c_answer: cover property ($rose(miso_oe));
    c_frame: cover property ($rose(cs_n));
    c_wp_low: cover property (!wp_n && $fell(cs_n));
endmodule : flash_wp_monitor
`default_nettype wire

// >>> tb/spi_flash_write_protect_ctrl_tb.sv
`default_nettype none
module spi_flash_write_protect_ctrl_tb
    import flash_wp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset, req_valid, req_ready, wp_level, done, armed_out;
    logic [7:0]  req_op, status_out;
    logic [5:0]  req_bits, req_rx_bits;
    logic [31:0] req_tx;
    logic [15:0] rx_data;
    logic [15:0] cap_n = 16'h0000;
    logic [63:0] cap = 64'h0;
    int          errors, tests_run, cycles;

    flash_spi_if spi ();
    flash_wp_device i_flash_wp_device (.clk(clk), .reset(reset), .spi(spi),
        .status_out(status_out), .armed_out(armed_out));
    flash_wp_host i_flash_wp_host (.clk(clk), .reset(reset), .spi(spi), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_bits(req_bits), .req_tx(req_tx),
        .req_rx_bits(req_rx_bits), .wp_level(wp_level), .done(done), .rx_data(rx_data));
    flash_wp_monitor i_flash_wp_monitor (.clk(clk), .reset(reset), .cs_n(spi.cs_n),
        .sck(spi.sck), .mosi(spi.mosi), .miso(spi.miso), .miso_oe(spi.miso_oe),
        .wp_n(spi.wp_n));

    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            final_report();
        end
    end
    // Bits seen on the wire
    always @(posedge spi.sck)
        if (spi.cs_n === 1'b0)
        begin
            cap <= {cap[62:0], spi.mosi};
            cap_n <= cap_n + 16'h0001;
        end

    task automatic final_report;
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic chk_st(input logic [7:0] exp);
        check("status", {8'h00, exp}, {8'h00, status_out});
    endtask : chk_st

    // One whole frame, then the device settle time
    task automatic send(input logic [7:0] op, input logic [5:0] bits, input logic [31:0] tx,
                        input logic [5:0] rx);
        int n;
        logic [15:0] base;
        @(negedge clk);
        base = cap_n;
        req_op = op;
        req_bits = bits;
        req_tx = tx;
        req_rx_bits = rx;
        req_valid = 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(negedge clk);
        check("bit count", {10'h000, bits} + {10'h000, rx} + 16'h0008, cap_n - base);
        check("opcode", {8'h00, op}, {8'h00, cap[bits + rx +: 8]});
    endtask : send

    task automatic wsr(input logic [7:0] d);
        send(WRITE_ARM_OP, 6'd0, 32'h0, 6'd0);
        send(STATUS_WRITE_OP, 6'd8, {d, 24'h0}, 6'd0);
    endtask : wsr

    // Main sequence
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        req_valid = 1'b0;
        req_op = 8'h00;
        req_bits = 6'd0;
        req_tx = 32'h0;
        req_rx_bits = 6'd0;
        wp_level = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        chk_st(STATUS_RESET);
        send(LATCH_SET_OP, 6'd0, 32'h0, 6'd0);
        chk_st(8'h0e);
        send(WRITE_ARM_OP, 6'd0, 32'h0, 6'd0);
        check("armed", 16'h0001, {15'h0, armed_out});
        send(LATCH_CLEAR_OP, 6'd0, 32'h0, 6'd0);
        chk_st(8'h0c);
        check("armed", 16'h0000, {15'h0, armed_out});
        wsr(8'hf7);
        chk_st(8'h84);
        wp_level = 1'b0;
        wsr(8'h08);
        chk_st(8'h84);
        wp_level = 1'b1;
        wsr(8'h00);
        chk_st(8'h00);
        wp_level = 1'b0;
        wsr(8'h8c);
        chk_st(8'h8c);
        wsr(8'h00);
        chk_st(8'h8c);
        wp_level = 1'b1;
        wsr(8'h00);
        chk_st(8'h00);
        // Arming lost when another frame intervenes
        send(WRITE_ARM_OP, 6'd0, 32'h0, 6'd0);
        send(LATCH_SET_OP, 6'd0, 32'h0, 6'd0);
        send(STATUS_WRITE_OP, 6'd8, 32'h0c00_0000, 6'd0);
        chk_st(8'h02);
        send(STATUS_READ_OP, 6'd0, 32'h0, 6'd16);
        check("status read", 16'h0202, rx_data);
        send(LATCH_CLEAR_OP, 6'd0, 32'h0, 6'd0);
        // Unknown opcode and wrong length drop arming, change no status bit
        send(WRITE_ARM_OP, 6'd0, 32'h0, 6'd0);
        send(8'hff, 6'd0, 32'h0, 6'd0);
        check("armed", 16'h0000, {15'h0, armed_out});
        send(STATUS_WRITE_OP, 6'd8, 32'h0c00_0000, 6'd0);
        chk_st(8'h00);
        send(WRITE_ARM_OP, 6'd0, 32'h0, 6'd0);
        send(STATUS_WRITE_OP, 6'd16, 32'h0c0c_0000, 6'd0);
        chk_st(8'h00);
        // Identification with both opcodes and both start addresses
        for (int k = 0; k < 4; k++)
        begin
            send(k[1] ? IDENT_OP_B : IDENT_OP_A, 6'd24, {23'h0, k[0], 8'h00}, 6'd32);
            check("ident", k[0] ? {PART_CODE, MAKER_CODE} : {MAKER_CODE, PART_CODE},
                  rx_data);
        end
        final_report();
    end
endmodule : spi_flash_write_protect_ctrl_tb
`default_nettype wire
